// ===== three_timer_counter_unit.sv
// three timer/counter unit with register access over AXI4-Lite
// Contract
// - timer function counts once per machine cycle of 12 oscillator periods.
// - counter function samples pin once per cycle, counts on high-then-low samples.
// - detected fall becomes visible at update phase of following machine cycle.
// - per-timer source-select bit and two-bit mode field in mode register.
// - mode 0 counts 13 bits, high byte plus low five bits; rollover sets flag.
// - timers 0/1 count only while run bit set and gate clear or irq pin high.
// - setting the run bit leaves the count registers untouched.
// - gate bits sit at mode register bit 7 (timer 1) and bit 3 (timer 0).
// - mode 1 is mode 0 using all sixteen bits.
// - mode 2 counts low byte, overflow sets flag and reloads from high byte.
// - timer 1 in mode 3 holds its count, as if run bit cleared.
// - timer 0 mode 3 splits: low byte own controls, high byte uses timer 1's.
// - with timer 0 in mode 3, timer 1 runs unless in mode 3, still baud source.
// - overflow flags at control bits 7 and 5 set on overflow, cleared on vectoring.
// - irq edge flags set on edge or low level per type bit, cleared on processing.
// - timer 2 overflow flag set on overflow, never while a serial source bit set.
// - timer 2 external flag set when trigger fall causes capture or reload.
// - serial source bits route timer 2 or timer 1 overflows to serial clocks.
// - external enable permits trigger capture/reload unless serial-clocking; else ignored.
// - timer 2 runs while run bit set; source bit picks cycles or pin falls.
// - bit 0 picks capture or reload; serial clocking forces reload on overflow.
// - capture copies timer 2 low and high bytes into capture/reload registers.
// - reload loads capture/reload registers into timer 2 on rollover or trigger.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
module three_timer_counter_unit import timer_unit_pkg::*; #(
  parameter int ADDR_W = 6
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic COUNT_INPUT_0,
  input wire logic COUNT_INPUT_1,
  input wire logic COUNT_INPUT_2,
  input wire logic CAPTURE_TRIGGER_PIN,
  input wire logic EXT_IRQ_PIN_0,
  input wire logic EXT_IRQ_PIN_1,
  output logic RX_BAUD_TICK,
  output logic TX_BAUD_TICK,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W must be at least 6");
  end

  unit_state_t r;
  unit_state_t n;

  // one count step for modes 0..2: {overflow, high, low}
  function automatic logic [16:0] cnt_step(input logic [1:0] m, input logic [7:0] h,
                                           input logic [7:0] l);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, h, l[4:0]} + 14'h0001;
    s16 = {1'b0, h, l} + 17'h00001;
    s8 = {1'b0, l} + 9'h001;
    case (m)
      2'h0: cnt_step = {s13[13], s13[12:5], l[7:5], s13[4:0]};
      2'h1: cnt_step = s16;
      default: cnt_step = {s8[8], h, (s8[8] ? h : s8[7:0])};
    endcase
  endfunction

  function automatic logic [8:0] inc8(input logic [7:0] v);
    inc8 = {1'b0, v} + 9'h001;
  endfunction

  logic smp_ph, upd_ph, t0m3, t1m3, baud, en0, en1, wr_go, rd_go;
  logic [3:0] fall;
  logic [2:0] tick;
  logic [16:0] res;
  logic [8:0] r8;
  logic [16:0] s2;
  logic set_tf0, set_tf1, set_tf2, set_external_event_flag, set_ie0, set_ie1, ovf1, ovf2;
  logic [5:0] wa;
  logic [5:0] ra;
  logic [7:0] wv;
  logic [7:0] rv;
  logic rd_hit;

  assign wa = r.aw_addr;
  assign ra = S_AXI_ARADDR[5:0];
  assign wv = r.w_data[7:0];
  assign wr_go = r.aw_ok && r.w_ok && !r.bvalid;
  assign rd_go = S_AXI_ARVALID && r.arrdy;

  always_comb begin
    n = r;
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    set_tf2 = 1'b0;
    set_external_event_flag = 1'b0;
    set_ie0 = 1'b0;
    set_ie1 = 1'b0;
    ovf1 = 1'b0;
    ovf2 = 1'b0;
    res = 17'h00000;
    r8 = 9'h000;
    s2 = 17'h00000;
    rv = 8'h00;
    rd_hit = 1'b1;
    // pins cross into the clock domain through two flops
    n.sync1 = {EXT_IRQ_PIN_1, EXT_IRQ_PIN_0, CAPTURE_TRIGGER_PIN,
               COUNT_INPUT_2, COUNT_INPUT_1, COUNT_INPUT_0};
    n.sync2 = r.sync1;
    n.ph = (r.ph == MC_LAST) ? 4'h0 : r.ph + 4'h1;
    smp_ph = (r.ph == SAMPLE_PH);
    upd_ph = (r.ph == UPDATE_PH);
    fall = r.smp & ~r.sync2[3:0];
    if (smp_ph) begin
      n.smp = r.sync2[3:0];
      n.pend = r.pend | fall;
      n.irq_prev = r.sync2[5:4];
      set_ie0 = r.timer_control_reg[IT0_B] ? (r.irq_prev[0] && !r.sync2[4]) : !r.sync2[4];
      set_ie1 = r.timer_control_reg[IT1_B] ? (r.irq_prev[1] && !r.sync2[5]) : !r.sync2[5];
    end
    t0m3 = (r.timer_mode_reg[1:0] == 2'h3);
    t1m3 = (r.timer_mode_reg[5:4] == 2'h3);
    baud = r.timer2_control_reg[RXSRC_B] || r.timer2_control_reg[TXSRC_B];
    tick[0] = r.timer_mode_reg[2] ? r.pend[0] : 1'b1;
    tick[1] = r.timer_mode_reg[6] ? r.pend[1] : 1'b1;
    tick[2] = r.timer2_control_reg[CT2_B] ? r.pend[2] : 1'b1;
    en0 = r.timer_control_reg[TR0_B] && (!r.timer_mode_reg[3] || r.sync2[4]);
    en1 = t0m3 ? !t1m3
               : (r.timer_control_reg[TR1_B] && (!r.timer_mode_reg[7] || r.sync2[5]) && !t1m3);
    if (upd_ph) begin
      n.pend = 4'h0;
      if (t0m3) begin
        if (en0 && tick[0]) begin
          r8 = inc8(r.tl0);
          n.tl0 = r8[7:0];
          set_tf0 = r8[8];
        end
        if (r.timer_control_reg[TR1_B]) begin
          r8 = inc8(r.th0);
          n.th0 = r8[7:0];
          set_tf1 = r8[8];
        end
      end else if (en0 && tick[0]) begin
        res = cnt_step(r.timer_mode_reg[1:0], r.th0, r.tl0);
        {set_tf0, n.th0, n.tl0} = res;
      end
      if (en1 && tick[1]) begin
        res = cnt_step(r.timer_mode_reg[5:4], r.th1, r.tl1);
        n.th1 = res[15:8];
        n.tl1 = res[7:0];
        ovf1 = res[16];
        if (!t0m3) begin
          set_tf1 = res[16];
        end
      end
      if (r.timer2_control_reg[TR2_B] && tick[2]) begin
        s2 = {1'b0, r.th2, r.tl2} + 17'h00001;
        {n.th2, n.tl2} = s2[15:0];
        if (s2[16]) begin
          ovf2 = 1'b1;
          set_tf2 = !baud;
          if (baud || !r.timer2_control_reg[CP_B]) begin
            {n.th2, n.tl2} = {r.rch, r.rcl};
          end
        end
      end
      if (r.pend[3] && r.timer2_control_reg[EXEN_B] && !baud) begin
        set_external_event_flag = 1'b1;
        if (r.timer2_control_reg[CP_B]) begin
          n.rcl = r.tl2;
          n.rch = r.th2;
        end else begin
          {n.th2, n.tl2} = {r.rch, r.rcl};
        end
      end
    end
    n.rx_tick = r.timer2_control_reg[RXSRC_B] ? ovf2 : ovf1;
    n.tx_tick = r.timer2_control_reg[TXSRC_B] ? ovf2 : ovf1;
    // write side: address and data may arrive in either order
    if (S_AXI_AWVALID && r.awrdy) begin
      n.aw_ok = 1'b1;
      n.aw_addr = S_AXI_AWADDR[5:0];
    end
    if (S_AXI_WVALID && r.wrdy) begin
      n.w_ok = 1'b1;
      n.w_data = S_AXI_WDATA;
      n.w_lane0 = S_AXI_WSTRB[0];
    end
    if (r.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      // software writes win over counting in the same cycle; run bits never clear counts
      unique case (wa)
        TIMER_CONTROL_OFS: if (r.w_lane0) n.timer_control_reg = wv;
        TIMER_MODE_OFS: if (r.w_lane0) n.timer_mode_reg = wv;
        COUNTER0_LOW_OFS: if (r.w_lane0) n.tl0 = wv;
        COUNTER0_HIGH_OFS: if (r.w_lane0) n.th0 = wv;
        COUNTER1_LOW_OFS: if (r.w_lane0) n.tl1 = wv;
        COUNTER1_HIGH_OFS: if (r.w_lane0) n.th1 = wv;
        TIMER2_CONTROL_OFS: if (r.w_lane0) n.timer2_control_reg = wv;
        COUNTER2_LOW_OFS: if (r.w_lane0) n.tl2 = wv;
        COUNTER2_HIGH_OFS: if (r.w_lane0) n.th2 = wv;
        CAPTURE_RELOAD_LOW_OFS: if (r.w_lane0) n.rcl = wv;
        CAPTURE_RELOAD_HIGH_OFS: if (r.w_lane0) n.rch = wv;
        VECTOR_ACK_OFS: if (r.w_lane0) begin
          n.timer_control_reg[TF0_B] = n.timer_control_reg[TF0_B] && !wv[ACK_TF0_B];
          n.timer_control_reg[TF1_B] = n.timer_control_reg[TF1_B] && !wv[ACK_TF1_B];
          n.timer_control_reg[IE0_B] = n.timer_control_reg[IE0_B] && !wv[ACK_IE0_B];
          n.timer_control_reg[IE1_B] = n.timer_control_reg[IE1_B] && !wv[ACK_IE1_B];
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // hardware sets win over any clear in the same cycle
    n.timer_control_reg[TF0_B] = n.timer_control_reg[TF0_B] || set_tf0;
    n.timer_control_reg[TF1_B] = n.timer_control_reg[TF1_B] || set_tf1;
    n.timer_control_reg[IE0_B] = n.timer_control_reg[IE0_B] || set_ie0;
    n.timer_control_reg[IE1_B] = n.timer_control_reg[IE1_B] || set_ie1;
    n.timer2_control_reg[TF2_B] = n.timer2_control_reg[TF2_B] || set_tf2;
    n.timer2_control_reg[EXTERNAL_EVENT_FLAG_B] = n.timer2_control_reg[EXTERNAL_EVENT_FLAG_B] || set_external_event_flag;
    n.awrdy = !n.aw_ok;
    n.wrdy = !n.w_ok;
    // read side: one read at a time, answered the cycle after acceptance
    unique case (ra)
      TIMER_CONTROL_OFS: rv = r.timer_control_reg;
      TIMER_MODE_OFS: rv = r.timer_mode_reg;
      COUNTER0_LOW_OFS: rv = r.tl0;
      COUNTER0_HIGH_OFS: rv = r.th0;
      COUNTER1_LOW_OFS: rv = r.tl1;
      COUNTER1_HIGH_OFS: rv = r.th1;
      TIMER2_CONTROL_OFS: rv = r.timer2_control_reg;
      COUNTER2_LOW_OFS: rv = r.tl2;
      COUNTER2_HIGH_OFS: rv = r.th2;
      CAPTURE_RELOAD_LOW_OFS: rv = r.rcl;
      CAPTURE_RELOAD_HIGH_OFS: rv = r.rch;
      VECTOR_ACK_OFS: rv = 8'h00;
      default: rd_hit = 1'b0;
    endcase
    if (r.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rdata = {24'h000000, rv};
      n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    n.arrdy = !n.rvalid;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign RX_BAUD_TICK = r.rx_tick;
  assign TX_BAUD_TICK = r.tx_tick;
  assign S_AXI_AWREADY = r.awrdy;
  assign S_AXI_WREADY = r.wrdy;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_ARREADY = r.arrdy;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RDATA = r.rdata;
  assign S_AXI_RRESP = r.rresp;

  // timer 0, 16-bit timer function, counts exactly one per update phase
  AST_T0_TIMER_TICK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (upd_ph && r.timer_mode_reg[3:0] == 4'h1 && r.timer_control_reg[TR0_B] && !wr_go)
    |=> {r.th0, r.tl0} == $past({r.th0, r.tl0}) + 16'h0001)
    else $error("timer 0 did not advance by one at update phase");

  AST_NO_COUNT_OFF_PHASE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!upd_ph && !wr_go) |=> (r.tl0 == $past(r.tl0) && r.tl1 == $past(r.tl1)))
    else $error("count changed outside update phase");

  AST_FALL_CONSUMED: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (smp_ph && fall[0]) |=> r.pend[0] [*7] ##1 !r.pend[0])
    else $error("pending count edge not consumed at next update phase");

  AST_GATED_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!t0m3 && !en0 && !wr_go) |=> (r.tl0 == $past(r.tl0) && r.th0 == $past(r.th0)))
    else $error("timer 0 counted while stopped or gated");

  AST_MODE2_RELOAD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (upd_ph && r.timer_mode_reg[1:0] == 2'h2 && en0 && tick[0] && r.tl0 == 8'hFF && !wr_go)
    |=> (r.tl0 == r.th0 && r.timer_control_reg[TF0_B] && $stable(r.th0)))
    else $error("mode 2 overflow did not reload low byte and set flag");

  AST_T1_MODE3_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (t1m3 && !wr_go) |=> ($stable(r.tl1) && $stable(r.th1)))
    else $error("timer 1 moved while in mode 3");

  AST_TF2_NOT_IN_BAUD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (baud && !r.timer2_control_reg[TF2_B] && !wr_go) |=> !r.timer2_control_reg[TF2_B])
    else $error("timer 2 overflow flag set while clocking serial port");

  AST_EXTERNAL_EVENT_FLAG_NEEDS_ENABLE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!r.timer2_control_reg[EXEN_B] && !r.timer2_control_reg[EXTERNAL_EVENT_FLAG_B] && !wr_go) |=> !r.timer2_control_reg[EXTERNAL_EVENT_FLAG_B])
    else $error("external flag set with external enable clear");

  AST_CAPTURE_COPY: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (upd_ph && r.pend[3] && r.timer2_control_reg[EXEN_B] && !baud && r.timer2_control_reg[CP_B] && !wr_go)
    |=> (r.rcl == $past(r.tl2) && r.rch == $past(r.th2)))
    else $error("trigger fall did not capture timer 2 count");

  AST_ACK_CLEARS_TF0: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (wr_go && wa == VECTOR_ACK_OFS && r.w_lane0 && wv[ACK_TF0_B] && !set_tf0)
    |=> !r.timer_control_reg[TF0_B])
    else $error("vector acknowledge did not clear timer 0 flag");

endmodule

// ===== timer_unit_pkg.sv
// constants, offsets and state layout shared by the timer/counter unit
package timer_unit_pkg;

  // register byte offsets on the register bus
  localparam logic [5:0] TIMER_CONTROL_OFS = 6'h00;
  localparam logic [5:0] TIMER_MODE_OFS = 6'h04;
  localparam logic [5:0] COUNTER0_LOW_OFS = 6'h08;
  localparam logic [5:0] COUNTER0_HIGH_OFS = 6'h0C;
  localparam logic [5:0] COUNTER1_LOW_OFS = 6'h10;
  localparam logic [5:0] COUNTER1_HIGH_OFS = 6'h14;
  localparam logic [5:0] TIMER2_CONTROL_OFS = 6'h18;
  localparam logic [5:0] COUNTER2_LOW_OFS = 6'h1C;
  localparam logic [5:0] COUNTER2_HIGH_OFS = 6'h20;
  localparam logic [5:0] CAPTURE_RELOAD_LOW_OFS = 6'h24;
  localparam logic [5:0] CAPTURE_RELOAD_HIGH_OFS = 6'h28;
  localparam logic [5:0] VECTOR_ACK_OFS = 6'h2C;

  // machine cycle: 12 oscillator periods, phases counted 0..11 from S1P1
  localparam logic [3:0] MC_LAST = 4'hB;
  localparam logic [3:0] SAMPLE_PH = 4'h9;
  localparam logic [3:0] UPDATE_PH = 4'h4;

  // timer_control_reg fields
  localparam int TF1_B = 7;
  localparam int TR1_B = 6;
  localparam int TF0_B = 5;
  localparam int TR0_B = 4;
  localparam int IE1_B = 3;
  localparam int IT1_B = 2;
  localparam int IE0_B = 1;
  localparam int IT0_B = 0;
  // timer2_control_reg fields
  localparam int TF2_B = 7;
  localparam int EXTERNAL_EVENT_FLAG_B = 6;
  localparam int RXSRC_B = 5;
  localparam int TXSRC_B = 4;
  localparam int EXEN_B = 3;
  localparam int TR2_B = 2;
  localparam int CT2_B = 1;
  localparam int CP_B = 0;
  // vector acknowledge bits
  localparam int ACK_TF0_B = 0;
  localparam int ACK_TF1_B = 1;
  localparam int ACK_IE0_B = 2;
  localparam int ACK_IE1_B = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;

  // pin vector index: count inputs 0..2, trigger, irq pins
  localparam int PIN_N = 6;

  typedef struct packed {
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic [3:0] ph;
    logic [3:0] smp;
    logic [1:0] irq_prev;
    logic [3:0] pend;
    logic [7:0] timer_mode_reg;
    logic [7:0] timer_control_reg;
    logic [7:0] timer2_control_reg;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] tl2;
    logic [7:0] th2;
    logic [7:0] rcl;
    logic [7:0] rch;
    logic aw_ok;
    logic [5:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic w_lane0;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rx_tick;
    logic tx_tick;
  } unit_state_t;

endpackage

// ===== pin_model.sv
// model of the external count, trigger and interrupt pins
module pin_model (
  input wire logic clk,
  output logic [5:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 6'h3F;
  // each level stands one machine cycle or longer, random extra hold
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      pins[idx] <= 1'b0;
      repeat (12 + $urandom_range(0, 6)) @(posedge clk);
      pins[idx] <= 1'b1;
      repeat (12 + $urandom_range(0, 6)) @(posedge clk);
    end
  endtask
  task automatic setp(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
  endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the timer/counter unit
module tb_top import timer_unit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic [1:0] rs;} rexp_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] pins;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_tick, tx_tick;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  rexp_t rq[$];
  logic [1:0] wq[$];
  int num_errors = 0, cmp_count = 0, rx_n = 0, tx_n = 0;
  always #50 clk = ~clk;
  pin_model i_pins (.clk(clk), .pins(pins));
  three_timer_counter_unit i_dut (.CLK(clk), .RST_B(rst_b),
    .COUNT_INPUT_0(pins[0]), .COUNT_INPUT_1(pins[1]), .COUNT_INPUT_2(pins[2]),
    .CAPTURE_TRIGGER_PIN(pins[3]), .EXT_IRQ_PIN_0(pins[4]), .EXT_IRQ_PIN_1(pins[5]),
    .RX_BAUD_TICK(rx_tick), .TX_BAUD_TICK(tx_tick),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo;
    num_errors++;
    wrap_up();
  endtask
  task automatic cmp_val(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    cmp_count++;
    if (sn !== ex) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic cmp_rd(input rexp_t e, input logic [31:0] d, input logic [1:0] r);
    cmp_count++;
    if (!(r === e.rs && ((d >= {24'h0, e.lo} && d <= {24'h0, e.hi}) === 1'b1))) begin
      num_errors++;
      $display("mismatch rdata expected %h..%h/%h seen %h/%h", e.lo, e.hi, e.rs, d, r);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wq.push_back(r);
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    bready <= 1'b0;
    if (!bvalid) tmo();
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] lo, input logic [7:0] hi,
                    input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back(rexp_t'{lo, hi, r});
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    rready <= 1'b0;
    if (!rvalid) tmo();
  endtask
  // counting lands within two machine cycles of the last fall
  task automatic settle;
    repeat (36) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rvalid && rready) cmp_rd(rq.pop_front(), rdata, rresp);
    if (bvalid && bready) cmp_val("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
    if (rx_tick) rx_n++;
    if (tx_tick) tx_n++;
  end
  initial begin
    repeat (50000) @(posedge clk);
    tmo();
  end
  initial begin
    logic [7:0] r0;
    void'($urandom(32'hAC39));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++) rd(6'(i * 4), 8'h00, 8'h00);
    rd(6'h30, 8'h00, 8'h00, RESP_SLVERR);
    wr(6'h3C, 8'hFF, RESP_SLVERR);
    // carry out of the low byte proves the full 16-bit count
    r0 = 8'(8'hF0 + $urandom_range(0, 12));
    wr(TIMER_MODE_OFS, 8'h01);
    wr(COUNTER0_LOW_OFS, r0);
    wr(TIMER_CONTROL_OFS, 8'h10);
    repeat (240) @(posedge clk);
    wr(TIMER_CONTROL_OFS, 8'h00);
    rd(COUNTER0_LOW_OFS, 8'(r0 + 19), 8'(r0 + 22));
    rd(COUNTER0_HIGH_OFS, 8'h01, 8'h01);
    wr(TIMER_MODE_OFS, 8'hC6);
    wr(COUNTER0_LOW_OFS, 8'hFE);
    wr(COUNTER0_HIGH_OFS, 8'h50);
    wr(COUNTER1_LOW_OFS, 8'hFD);
    wr(COUNTER1_HIGH_OFS, 8'hFF);
    i_pins.setp(5, 1'b0);
    wr(TIMER_CONTROL_OFS, 8'h51);
    rx_n = 0;
    tx_n = 0;
    i_pins.pulse(1, 2);
    i_pins.pulse(0, 3);
    i_pins.setp(5, 1'b1);
    i_pins.pulse(1, 3);
    i_pins.pulse(4, 1);
    settle();
    rd(COUNTER1_LOW_OFS, 8'hE0, 8'hE0);
    rd(COUNTER1_HIGH_OFS, 8'h00, 8'h00);
    rd(COUNTER0_LOW_OFS, 8'h51, 8'h51);
    rd(COUNTER0_HIGH_OFS, 8'h50, 8'h50);
    rd(TIMER_CONTROL_OFS, 8'hFB, 8'hFB);
    cmp_val("rx_ticks", 1, rx_n);
    cmp_val("tx_ticks", 1, tx_n);
    wr(VECTOR_ACK_OFS, 8'h0F);
    rd(TIMER_CONTROL_OFS, 8'h51, 8'h51);
    wr(TIMER_MODE_OFS, 8'h31);
    wr(TIMER_CONTROL_OFS, 8'h40);
    wr(COUNTER0_HIGH_OFS, 8'h00);
    repeat (120) @(posedge clk);
    rd(COUNTER1_LOW_OFS, 8'hE0, 8'hE0);
    wr(TIMER_MODE_OFS, 8'h33);
    repeat (240) @(posedge clk);
    wr(TIMER_CONTROL_OFS, 8'h00);
    rd(COUNTER0_HIGH_OFS, 8'h13, 8'h16);
    rd(COUNTER0_LOW_OFS, 8'h51, 8'h51);
    rd(COUNTER1_LOW_OFS, 8'hE0, 8'hE0);
    rd(TIMER_CONTROL_OFS, 8'h00, 8'h00);
    wr(COUNTER2_LOW_OFS, 8'h10);
    wr(COUNTER2_HIGH_OFS, 8'h33);
    wr(TIMER2_CONTROL_OFS, 8'h0F);
    i_pins.pulse(2, 5);
    i_pins.pulse(3, 1);
    settle();
    rd(CAPTURE_RELOAD_LOW_OFS, 8'h15, 8'h15);
    rd(CAPTURE_RELOAD_HIGH_OFS, 8'h33, 8'h33);
    rd(TIMER2_CONTROL_OFS, 8'h4F, 8'h4F);
    wr(TIMER2_CONTROL_OFS, 8'h00);
    wr(CAPTURE_RELOAD_LOW_OFS, 8'h34);
    wr(CAPTURE_RELOAD_HIGH_OFS, 8'h12);
    wr(COUNTER2_LOW_OFS, 8'hFE);
    wr(COUNTER2_HIGH_OFS, 8'hFF);
    wr(TIMER2_CONTROL_OFS, 8'h0E);
    i_pins.pulse(2, 3);
    settle();
    rd(COUNTER2_LOW_OFS, 8'h35, 8'h35);
    rd(COUNTER2_HIGH_OFS, 8'h12, 8'h12);
    i_pins.pulse(3, 1);
    settle();
    rd(COUNTER2_LOW_OFS, 8'h34, 8'h34);
    rd(TIMER2_CONTROL_OFS, 8'hCE, 8'hCE);
    // serial clocking: capture bit and trigger pin both ignored
    wr(TIMER2_CONTROL_OFS, 8'h00);
    wr(COUNTER2_LOW_OFS, 8'hFF);
    wr(COUNTER2_HIGH_OFS, 8'hFF);
    wr(TIMER2_CONTROL_OFS, 8'h3F);
    rx_n = 0;
    tx_n = 0;
    i_pins.pulse(2, 2);
    i_pins.pulse(3, 1);
    settle();
    rd(COUNTER2_LOW_OFS, 8'h35, 8'h35);
    rd(TIMER2_CONTROL_OFS, 8'h3F, 8'h3F);
    rd(CAPTURE_RELOAD_LOW_OFS, 8'h34, 8'h34);
    cmp_val("rx_ticks", 1, rx_n);
    cmp_val("tx_ticks", 1, tx_n);
    wrap_up();
  end
endmodule
